// ===== rtl/uee_top.sv
`include "uee_cfg.svh"
`default_nettype none
// Function
// - per-endpoint eight enables, reset zero
// - bit 7 set on transaction error
// - bit 6 set on STALL answer
// - bit 5 set on NAK answer
// - bit 4 set after IN data acked
// - bit 3 set on any IN token
// - bit 2 set when OUT bytes exceed packet length
// - bit 1 set after OUT data acked
// - bit 0 set on OUT token
// - flags reset zero, write one clears
// - buffer-0 count bits 9:0, OUT loads it
// - buffer-1 count bits 25:16, reset zero
// - single buffer uses only buffer-0 count
// - config bit 23 selects double buffering
// - packet length bits 19:10 judges overrun
module uee_top #(
  parameter int NUM_EP = 4
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [11:0]               avs_address_i,
  input  wire logic                      avs_read_i,
  input  wire logic                      avs_write_i,
  input  wire logic [31:0]               avs_writedata_i,
  input  wire logic [3:0]                avs_byteenable_i,
  output logic [31:0]                    avs_readdata_o,
  output logic                           avs_waitrequest_o,
  input  wire uee_pkg::uee_evt_t [NUM_EP-1:0] evt_i,
  output logic [NUM_EP-1:0]              ep_irq_o,
  output logic                           irq_o
);
  uee_pkg::uee_bus_st_t st_r, st_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] cfg_r [NUM_EP];
  logic [31:0] cfg_nxt [NUM_EP];
  logic        req;
  logic [NUM_EP-1:0] irq_v;
  logic [31:0] rd_mux;

  uee_ep_if epif [NUM_EP] ();

  assign req = avs_read_i || avs_write_i;

  // ----------------------------------------
  // per-endpoint decode and state
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : gen_ep
      localparam logic [11:0] BASE_E = `UEE_OFS_ENABLE + 12'(g) * `UEE_EP_STRIDE;
      localparam logic [11:0] BASE_F = `UEE_OFS_FLAGS  + 12'(g) * `UEE_EP_STRIDE;
      localparam logic [11:0] BASE_C = `UEE_OFS_COUNTS + 12'(g) * `UEE_EP_STRIDE;
      localparam logic [11:0] BASE_G = `UEE_OFS_CONFIG + 12'(g) * `UEE_EP_STRIDE;
      logic wr_now;
      assign wr_now = avs_write_i && (st_r == uee_pkg::UEE_ACK) && (&avs_byteenable_i);
      assign epif[g].wdata        = avs_writedata_i;
      assign epif[g].wr_enable    = wr_now && (avs_address_i == BASE_E);
      assign epif[g].wr_counts    = wr_now && (avs_address_i == BASE_C);
      assign epif[g].wr_flags_clr = (wr_now && (avs_address_i == BASE_F)) ? avs_writedata_i[7:0] : 8'h00;
      assign irq_v[g] = epif[g].irq;

      always_comb
      begin
        cfg_nxt[g] = cfg_r[g];
        if (wr_now && (avs_address_i == BASE_G))
          cfg_nxt[g] = avs_writedata_i;
      end

      always_ff @(posedge mclk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          cfg_r[g] <= `UEE_RST_CONFIG;
        else
          cfg_r[g] <= cfg_nxt[g];
      end

      uee_ep u_ep (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .dbuf_i    (cfg_r[g][`UEE_CFG_DBUF_BIT]),
        .len_i     (cfg_r[g][`UEE_CFG_LEN_LSB +: 10]),
        .evt_i     (evt_i[g]),
        .bus       (epif[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    rd_mux = `UEE_RD_ZERO;
    if (avs_address_i == `UEE_OFS_IRQ_SUM)
      rd_mux = 32'(irq_v);
    for (int i = 0; i < NUM_EP; i++)
    begin
      if (avs_address_i == `UEE_OFS_ENABLE + 12'(i) * `UEE_EP_STRIDE)
        rd_mux = {24'h000000, epif_enable(i)};
      if (avs_address_i == `UEE_OFS_FLAGS + 12'(i) * `UEE_EP_STRIDE)
        rd_mux = {24'h000000, epif_flags(i)};
      if (avs_address_i == `UEE_OFS_COUNTS + 12'(i) * `UEE_EP_STRIDE)
        rd_mux = {6'h00, epif_cnt1(i), 6'h00, epif_cnt0(i)};
      if (avs_address_i == `UEE_OFS_CONFIG + 12'(i) * `UEE_EP_STRIDE)
        rd_mux = cfg_r[i];
    end
  end

  // interface arrays need constant indices, so flatten them
  logic [7:0] en_a [NUM_EP];
  logic [7:0] fl_a [NUM_EP];
  logic [9:0] c0_a [NUM_EP];
  logic [9:0] c1_a [NUM_EP];
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : gen_flat
      assign en_a[g] = epif[g].enable;
      assign fl_a[g] = epif[g].flags;
      assign c0_a[g] = epif[g].cnt0;
      assign c1_a[g] = epif[g].cnt1;
    end
  endgenerate

  function automatic logic [7:0] epif_enable(input int i);
    return en_a[i];
  endfunction
  function automatic logic [7:0] epif_flags(input int i);
    return fl_a[i];
  endfunction
  function automatic logic [9:0] epif_cnt0(input int i);
    return c0_a[i];
  endfunction
  function automatic logic [9:0] epif_cnt1(input int i);
    return c1_a[i];
  endfunction

  // ----------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    rd_nxt = rd_r;
    unique case (st_r)
      uee_pkg::UEE_IDLE:
      begin
        if (req)
        begin
          st_nxt = uee_pkg::UEE_ACK;
          if (avs_read_i)
            rd_nxt = rd_mux;
        end
      end
      uee_pkg::UEE_ACK:
      begin
        st_nxt = uee_pkg::UEE_DONE;
      end
      uee_pkg::UEE_DONE:
        st_nxt = uee_pkg::UEE_IDLE;
      default:
        st_nxt = uee_pkg::UEE_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= uee_pkg::UEE_IDLE;
      rd_r <= `UEE_RD_ZERO;
    end
    else
    begin
      st_r <= st_nxt;
      rd_r <= rd_nxt;
    end
  end

  // waitrequest drops in the ACK cycle; read data registered on entry to it
  assign avs_waitrequest_o = !(st_r == uee_pkg::UEE_ACK);
  assign avs_readdata_o    = rd_r;
  assign ep_irq_o          = irq_v;
  assign irq_o             = |irq_v;
endmodule
`default_nettype wire

// ===== rtl/uee_cfg.svh
`ifndef UEE_CFG_SVH
`define UEE_CFG_SVH
// register byte offsets for endpoint 0; endpoints 1..3 follow at a fixed stride
`define UEE_OFS_ENABLE   12'h068
`define UEE_OFS_FLAGS    12'h06c
`define UEE_OFS_COUNTS   12'h070
`define UEE_OFS_CONFIG   12'h074
`define UEE_EP_STRIDE    12'h014
`define UEE_OFS_IRQ_SUM  12'h0c0
// field positions
`define UEE_BIT_XFER_ERR   7
`define UEE_BIT_STALL      6
`define UEE_BIT_NAK        5
`define UEE_BIT_IN_DATA    4
`define UEE_BIT_IN_TOKEN   3
`define UEE_BIT_OVERRUN    2
`define UEE_BIT_OUT_DATA   1
`define UEE_BIT_OUT_TOKEN  0
`define UEE_CNT0_LSB       0
`define UEE_CNT1_LSB       16
`define UEE_CFG_DBUF_BIT   23
`define UEE_CFG_LEN_LSB    10
// reset values
`define UEE_RST_ENABLE   8'h00
`define UEE_RST_FLAGS    8'h00
`define UEE_RST_COUNT    10'h000
`define UEE_RST_CONFIG   32'h1000_03ff
`define UEE_RD_ZERO      32'h0000_0000
`endif

// ===== rtl/uee_pkg.sv
`default_nettype none
package uee_pkg;
  // slave answer state
  typedef enum logic [2:0] {
    UEE_IDLE = 3'b001,
    UEE_ACK  = 3'b010,
    UEE_DONE = 3'b100
  } uee_bus_st_t;
  // hardware event from packet engine for one endpoint
  typedef struct packed {
    logic       xfer_error;
    logic       stall_sent;
    logic       nak_sent;
    logic       in_acked;
    logic       in_token;
    logic       out_acked;
    logic       out_token;
    logic       out_done;
    logic [9:0] out_bytes;
    logic       out_buf1;
  } uee_evt_t;
endpackage
`default_nettype wire

// ===== rtl/uee_ep_if.sv
`default_nettype none
interface uee_ep_if;
  logic [7:0]  wr_flags_clr;
  logic        wr_enable;
  logic        wr_counts;
  logic [31:0] wdata;
  logic [7:0]  enable;
  logic [7:0]  flags;
  logic [9:0]  cnt0;
  logic [9:0]  cnt1;
  logic        irq;
  modport ctl (output wr_flags_clr, output wr_enable, output wr_counts, output wdata,
               input enable, input flags, input cnt0, input cnt1, input irq);
  modport ep  (input wr_flags_clr, input wr_enable, input wr_counts, input wdata,
               output enable, output flags, output cnt0, output cnt1, output irq);
endinterface
`default_nettype wire

// ===== rtl/uee_ep.sv
`include "uee_cfg.svh"
`default_nettype none
module uee_ep (
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic        dbuf_i,
  input  wire logic [9:0]  len_i,
  input  wire uee_pkg::uee_evt_t evt_i,
  uee_ep_if.ep             bus
);
  logic [7:0] en_r, en_nxt, fl_r, fl_nxt, set_v;
  logic [9:0] c0_r, c0_nxt, c1_r, c1_nxt;
  logic       ovr;

  // ----------------------------------------
  // event flags and counts
  // ----------------------------------------
  always_comb
  begin
    ovr = evt_i.out_done && (evt_i.out_bytes > len_i);
    set_v = 8'h00;
    set_v[`UEE_BIT_XFER_ERR]  = evt_i.xfer_error;
    set_v[`UEE_BIT_STALL]     = evt_i.stall_sent;
    set_v[`UEE_BIT_NAK]       = evt_i.nak_sent;
    set_v[`UEE_BIT_IN_DATA]   = evt_i.in_acked;
    set_v[`UEE_BIT_IN_TOKEN]  = evt_i.in_token;
    set_v[`UEE_BIT_OVERRUN]   = ovr;
    set_v[`UEE_BIT_OUT_DATA]  = evt_i.out_acked;
    set_v[`UEE_BIT_OUT_TOKEN] = evt_i.out_token;
    fl_nxt = (fl_r & ~bus.wr_flags_clr) | set_v;
    en_nxt = bus.wr_enable ? bus.wdata[7:0] : en_r;
    c0_nxt = c0_r;
    c1_nxt = c1_r;
    if (bus.wr_counts)
    begin
      c0_nxt = bus.wdata[`UEE_CNT0_LSB +: 10];
      c1_nxt = bus.wdata[`UEE_CNT1_LSB +: 10];
    end
    if (evt_i.out_done)
    begin
      // single buffer always counts in buffer 0
      if (dbuf_i && evt_i.out_buf1)
        c1_nxt = evt_i.out_bytes;
      else
        c0_nxt = evt_i.out_bytes;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_r <= `UEE_RST_ENABLE;
      fl_r <= `UEE_RST_FLAGS;
      c0_r <= `UEE_RST_COUNT;
      c1_r <= `UEE_RST_COUNT;
    end
    else
    begin
      en_r <= en_nxt;
      fl_r <= fl_nxt;
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
    end
  end

  assign bus.enable = en_r;
  assign bus.flags  = fl_r;
  assign bus.cnt0   = c0_r;
  assign bus.cnt1   = c1_r;
  assign bus.irq    = |(fl_r & en_r);
endmodule
`default_nettype wire

// ===== tb/uee_properties.sv
`default_nettype none
module uee_properties #(
  parameter int NUM_EP = 4
) (
  input wire logic               mclk_i,
  input wire logic               reset_n_i,
  input wire logic [11:0]        avs_address_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire logic [31:0]        avs_readdata_o,
  input wire logic               avs_waitrequest_o,
  input wire uee_pkg::uee_evt_t [NUM_EP-1:0] evt_i,
  input wire logic [NUM_EP-1:0]  ep_irq_o,
  input wire logic               irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic evt_any;
  always_comb
  begin
    evt_any = 1'b0;
    for (int i = 0; i < NUM_EP; i++) evt_any = evt_any | (|evt_i[i][18:11]);
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req; $rose(avs_read_i || avs_write_i); endsequence
  sequence s_ans; avs_waitrequest_o ##1 !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  a_answer_timing: assert property (s_req |-> s_ans) else $error("answer timing");
  a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low too long");
  a_wait_needs_req: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o) else $error("stray answer");
  a_irq_or: assert property (irq_o == |ep_irq_o) else $error("irq not or");
  a_irq_cause: assert property ($changed(ep_irq_o) |-> $past(avs_write_i) || $past(evt_any)) else $error("irq cause");
  a_irq_fall_write: assert property ($fell(irq_o) |-> $past(avs_write_i)) else $error("irq fell");
  a_unmapped_zero: assert property (s_req ##0 (avs_read_i && avs_address_i == 12'h0fc) |=>
    !avs_waitrequest_o && avs_readdata_o == 32'h0) else $error("unmapped read");
  a_summary_read: assert property ($rose(avs_read_i) && avs_address_i == 12'h0c0 |=>
    avs_readdata_o == 32'($past(ep_irq_o))) else $error("summary read");
endmodule
bind uee_top uee_properties #(.NUM_EP(NUM_EP)) u_props (.mclk_i, .reset_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .evt_i, .ep_irq_o, .irq_o);
`default_nettype wire

// ===== tb/uee_host_model.sv
`default_nettype none
module uee_host_model #(
  parameter int NUM_EP = 4
) (
  input  wire logic                          mclk_i,
  output var uee_pkg::uee_evt_t [NUM_EP-1:0] evt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt_o = '0;
  // token pulse, then answer pulse; count lines garbage outside it
  task automatic txn(input int e, input logic [7:0] t, input logic [7:0] a, input logic [9:0] n, input logic b);
    @(posedge mclk_i);
    evt_o[e] <= {t, ~n, ~b};
    @(posedge mclk_i);
    evt_o[e] <= {a, n, b};
    @(posedge mclk_i);
    evt_o[e] <= {8'h00, ~n, ~b};
    repeat (2) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/usb_endpoint_event_and_count_tb_top.sv
`default_nettype none
module usb_endpoint_event_and_count_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] XE = 8'h80, ST = 8'h40, NK = 8'h20, IA = 8'h10, IT = 8'h08, OA = 8'h04, OT = 8'h02;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [11:0] avs_address_i = 12'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [3:0]  ep_irq_o;
  logic        irq_o;
  logic [31:0] q;
  int          error_cnt = 0;
  int          tests_run = 0;
  uee_pkg::uee_evt_t [3:0] evt_i;
  initial forever #2.5 mclk_i = ~mclk_i;
  uee_top uut (.mclk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .evt_i, .ep_irq_o, .irq_o);
  uee_host_model host (.mclk_i, .evt_o(evt_i));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do
      @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  function automatic logic [11:0] ad(input int e, input int k);
    return 12'(12'h068 + 12'h014 * e + 4 * k);
  endfunction
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(nm, q, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic t_reset();
    for (int e = 0; e < 4; e++)
    begin
      rc("enable", ad(e, 0), 32'h0);
      rc("flags", ad(e, 1), 32'h0);
      rc("counts", ad(e, 2), 32'h0);
      rc("config", ad(e, 3), 32'h1000_03ff);
    end
    wr(12'h0fc, 32'hffff_ffff);
    rc("unmapped", 12'h0fc, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_events();
    logic [7:0] tk[6] = '{IT, IT, IT, OT, OT, OT};
    logic [7:0] an[6] = '{IA, NK, ST, OA | 8'h01, XE, OA | 8'h01};
    logic [7:0] ex[6] = '{8'h18, 8'h28, 8'h48, 8'h03, 8'h81, 8'h07};
    logic [9:0] nb[6] = '{10'd0, 10'd0, 10'd0, 10'd8, 10'd0, 10'd12};
    wr(ad(0, 3), 32'h0000_2000);
    wr(ad(0, 0), 32'hff);
    for (int i = 0; i < 6; i++)
    begin
      host.txn(0, tk[i], an[i], nb[i], 1'b0);
      rc("flags", ad(0, 1), 32'(ex[i]));
      chk("irq", 32'(irq_o), 32'h1);
      wr(ad(0, 1), 32'hff);
    end
    rc("count0", ad(0, 2), 32'd12);
    $display("test events done");
  endtask
  task automatic t_mask();
    wr(ad(2, 0), 32'h01);
    host.txn(2, IT, NK, 10'h0, 1'b0);
    rc("flags", ad(2, 1), 32'h28);
    chk("masked", 32'(ep_irq_o), 32'h0);
    wr(ad(2, 0), 32'h20);
    rc("enable", ad(2, 0), 32'h20);
    rc("summary", 12'h0c0, 32'h4);
    wr(ad(2, 1), 32'h0);
    rc("kept", ad(2, 1), 32'h28);
    wr(ad(2, 1), 32'h20);
    rc("one_clr", ad(2, 1), 32'h08);
    chk("irq_off", 32'(irq_o), 32'h0);
    // token lands before the clearing write, the nak answer in its accept cycle
    fork
      wr(ad(3, 1), 32'hff);
      host.txn(3, IT, NK, 10'h0, 1'b0);
    join
    rc("set_wins", ad(3, 1), 32'h20);
    $display("test mask done");
  endtask
  task automatic t_counts();
    wr(ad(1, 2), 32'h03ff_0155);
    rc("counts", ad(1, 2), 32'h03ff_0155);
    bus(1'b1, ad(1, 2), 32'h0, 4'h3);
    rc("partial", ad(1, 2), 32'h03ff_0155);
    host.txn(1, OT, OA | 8'h01, 10'd7, 1'b1);
    rc("single", ad(1, 2), 32'h03ff_0007);
    wr(ad(1, 3), 32'h0080_2000);
    host.txn(1, OT, OA | 8'h01, 10'd5, 1'b1);
    rc("double", ad(1, 2), 32'h0005_0007);
    $display("test counts done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_events();
    t_mask();
    t_counts();
    tally_and_finish();
  end
  initial
  begin
    #50000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
